/* File: logic/selftest_pkg.sv */
// Shared constants and types of the link self-test engine
package selftest_pkg;
  localparam logic [15:0] ADDR_CONTROL_A  = 16'h1AC0;
  localparam logic [15:0] ADDR_CONTROL_B  = 16'h1AC1;
  localparam logic [15:0] ADDR_ERR_HIGH   = 16'h1AC2;
  localparam logic [15:0] ADDR_ERR_LOW    = 16'h1AC3;
  localparam logic [15:0] ADDR_IRQ_STATUS = 16'h1AC4;
  localparam logic [15:0] ADDR_IRQ_MASK   = 16'h1AC5;
  localparam logic [15:0] ADDR_RX_STATUS  = 16'h1AC7;
  // Control A fields
  localparam int BIT_ENABLE    = 0;
  localparam int BIT_RX_SELECT = 1;
  localparam int POS_PATTERN   = 2;
  localparam int POS_SOP       = 5;
  // Control B fields
  localparam int BIT_TX_CLEAR  = 0;
  localparam int BIT_TX_GO     = 1;
  localparam int BIT_ERR_CLEAR = 2;
  // Receive status fields and interrupt events
  localparam int BIT_RX_LOCKED = 0;
  localparam int BIT_RX_ACTIVE = 1;
  localparam int BIT_RX_ERROR  = 2;
  localparam int IRQ_TX_DONE   = 0;
  localparam int IRQ_RX_LOCK   = 1;
  localparam int IRQ_RX_ERROR  = 2;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  // Timing
  localparam int CLOCK_MHZ       = 100;
  localparam int BIT_TIME_NS     = 3333;
  localparam int BIT_CYCLES      = (BIT_TIME_NS * CLOCK_MHZ) / 1000;
  localparam int LOCK_BITS       = 16;
  localparam int FRAME_BITS      = 1024;
  localparam logic [15:0] PRBS_SEED = 16'hACE1;
  // Five SOP ordered sets as 20-bit vectors, LSB sent first
  localparam logic [19:0] SOP_SET0 = 20'h8C631;
  localparam logic [19:0] SOP_SET1 = 20'h31C63;
  localparam logic [19:0] SOP_SET2 = 20'h98C63;
  localparam logic [19:0] SOP_SET3 = 20'h9CC31;
  localparam logic [19:0] SOP_SET4 = 20'h9CE31;
  typedef enum logic [2:0] {
    PAT_PRBS  = 3'h0,
    PAT_ONES  = 3'h1,
    PAT_ZEROS = 3'h2,
    PAT_ALT   = 3'h3,
    PAT_FRAME = 3'h4,
    PAT_EVEN  = 3'h5
  } pattern_type;
  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_SOP  = 2'b01,
    TX_BODY = 2'b11
  } tx_state_type;
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        write;
    logic        read;
  } bus_req_type;
endpackage : selftest_pkg

/* File: logic/selftest_prbs.sv */
// Sixteen-bit sequence generator shared by transmit and receive sides
`timescale 1ns/1ps
`default_nettype none
module selftest_prbs #(
  parameter logic [15:0] SEED = selftest_pkg::PRBS_SEED
) (
  input  wire logic sys_clk_i,
  input  wire logic reset_i,
  input  wire logic restart_i,
  input  wire logic step_i,
  input  wire logic load_i,
  input  wire logic load_bit_i,
  output logic      bit_o
);
  logic [15:0] state_q;
  logic        feedback;
  // Taps x16+x14+x13+x11+1
  assign feedback = state_q[15] ^ state_q[13] ^ state_q[12] ^ state_q[10];
  // Output is the bit about to enter, so a filled register predicts the next bit
  assign bit_o    = feedback;
  // Shift on each bit step, or take the received bit while locking
  always_ff @(posedge sys_clk_i) begin
    if (reset_i || restart_i) begin
      state_q <= SEED;
    end else if (step_i) begin
      state_q <= {state_q[14:0], load_i ? load_bit_i : feedback};
    end
  end
endmodule : selftest_prbs
`default_nettype wire

/* File: logic/selftest_engine.sv */
// Link self-test engine: pattern transmitter, error-checking receiver, registers
//
// Functional notes
// - Own sequence, pattern and bit timer for transmit
// - Register picks one of five 20-bit SOPs
// - Selected SOP sent one bit at a time
// - Transmit test when enabled and receive unselected
// - Pattern field selects transmitted test kind
// - Clear then go starts; go reads running
// - Transmitter stops within one bit time
// - Receive side checks bits against local sequence
// - Receive test when enabled and receive selected
// - Error-count clear bit zeroes the counter, or loads one with a same-cycle error
// - Error count read as high and low byte
`timescale 1ns/1ps
`default_nettype none
module selftest_engine #(
  parameter int BIT_CYCLES = selftest_pkg::BIT_CYCLES,
  parameter int FRAME_BITS = selftest_pkg::FRAME_BITS
) (
  input  wire logic        sys_clk_i,
  input  wire logic        reset_i,
  input  wire logic [15:0] addr_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic        write_i,
  input  wire logic        read_i,
  output logic      [7:0]  rdata_o,
  output logic             irq_o,
  output logic             tx_bit_o,
  output logic             tx_active_o,
  input  wire logic        rx_bit_i,
  input  wire logic        rx_strobe_i
);
  selftest_pkg::bus_req_type req;
  logic [7:0]  control_a_q;
  logic [7:0]  irq_status_q;
  logic [7:0]  irq_mask_q;
  logic [7:0]  rdata_q;
  logic [15:0] err_count_q;
  logic        tx_go_q;
  selftest_pkg::tx_state_type tx_state_q;
  logic [15:0] bit_timer_q;
  logic [4:0]  sop_index_q;
  logic [10:0] body_count_q;
  logic        tx_bit_q;
  logic        alt_q;
  logic [2:0]  rx_sync_q;
  logic [4:0]  lock_count_q;
  logic        rx_locked_q;
  logic        rx_error_q;
  logic        rx_bit_d1_q;
  logic        rx_bit_s;
  logic        rx_strobe_s;

  assign req = '{addr: addr_i, wdata: wdata_i, write: write_i, read: read_i};

  // Mode decode
  wire enable      = control_a_q[selftest_pkg::BIT_ENABLE];
  wire rx_select   = control_a_q[selftest_pkg::BIT_RX_SELECT];
  wire tx_mode     = enable && !rx_select;
  wire rx_mode     = enable && rx_select;
  wire [2:0] pattern = control_a_q[selftest_pkg::POS_PATTERN +: 3];
  wire [2:0] sop_sel = control_a_q[selftest_pkg::POS_SOP +: 3];

  // Register decode
  wire hit_a    = req.addr == selftest_pkg::ADDR_CONTROL_A;
  wire hit_b    = req.addr == selftest_pkg::ADDR_CONTROL_B;
  wire hit_hi   = req.addr == selftest_pkg::ADDR_ERR_HIGH;
  wire hit_lo   = req.addr == selftest_pkg::ADDR_ERR_LOW;
  wire hit_ists = req.addr == selftest_pkg::ADDR_IRQ_STATUS;
  wire hit_imsk = req.addr == selftest_pkg::ADDR_IRQ_MASK;
  wire hit_rxs  = req.addr == selftest_pkg::ADDR_RX_STATUS;
  wire wr_b     = req.write && hit_b;
  wire tx_clear = wr_b && req.wdata[selftest_pkg::BIT_TX_CLEAR];
  wire tx_go    = wr_b && req.wdata[selftest_pkg::BIT_TX_GO];
  wire err_clr  = wr_b && req.wdata[selftest_pkg::BIT_ERR_CLEAR];

  // SOP multiplexer to a static 20-bit vector
  wire [19:0] sop_vec = (sop_sel == 3'h0) ? selftest_pkg::SOP_SET0 :
                        (sop_sel == 3'h1) ? selftest_pkg::SOP_SET1 :
                        (sop_sel == 3'h2) ? selftest_pkg::SOP_SET2 :
                        (sop_sel == 3'h3) ? selftest_pkg::SOP_SET3 :
                                            selftest_pkg::SOP_SET4;

  // Bit timer: one-cycle enable per bit time, runs only while transmitting
  wire bit_tick = (bit_timer_q == 16'(BIT_CYCLES - 1));
  wire tx_run   = tx_state_q != selftest_pkg::TX_IDLE;
  wire framed   = pattern == selftest_pkg::PAT_FRAME;
  wire sop_last = sop_index_q == 5'd19;
  wire body_end = framed && (body_count_q == 11'(FRAME_BITS - 1));

  // Generator advances once per body bit taken from it, so no bit repeats
  wire body_load = tx_mode && !tx_clear &&
                   ((tx_state_q == selftest_pkg::TX_IDLE && tx_go && !tx_go_q && !framed) ||
                    (tx_state_q == selftest_pkg::TX_SOP && bit_tick && sop_last) ||
                    (tx_state_q == selftest_pkg::TX_BODY && bit_tick && !body_end));

  // Transmit sequence generator
  logic tx_prbs_bit;
  selftest_prbs #(.SEED(selftest_pkg::PRBS_SEED)) u_tx_prbs (
    .sys_clk_i  (sys_clk_i),
    .reset_i    (reset_i),
    .restart_i  (tx_clear),
    .step_i     (body_load),
    .load_i     (1'b0),
    .load_bit_i (1'b0),
    .bit_o      (tx_prbs_bit)
  );

  // Next transmitted bit by pattern kind
  logic next_bit;
  always_comb begin
    case (pattern)
      selftest_pkg::PAT_ONES:  next_bit = 1'b1;
      selftest_pkg::PAT_ZEROS: next_bit = 1'b0;
      selftest_pkg::PAT_ALT:   next_bit = alt_q;
      selftest_pkg::PAT_EVEN:  next_bit = ~alt_q;
      default:                 next_bit = tx_prbs_bit;
    endcase
  end

  // Control register A and interrupt mask
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      control_a_q <= selftest_pkg::RESET_BYTE;
      irq_mask_q  <= selftest_pkg::RESET_BYTE;
    end else begin
      if (req.write && hit_a) control_a_q <= req.wdata;
      if (req.write && hit_imsk) irq_mask_q <= req.wdata;
    end
  end

  // Go flag: set by software, cleared by clear bit, frame end or mode exit
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      tx_go_q <= 1'b0;
    end else if (tx_clear || !tx_mode) begin
      tx_go_q <= 1'b0;
    end else if (tx_go) begin
      tx_go_q <= 1'b1;
    end else if (bit_tick && body_end) begin
      tx_go_q <= 1'b0;
    end
  end

  // Bit timer restarts at go so the first bit is a full bit time
  always_ff @(posedge sys_clk_i) begin
    if (reset_i || !tx_run || bit_tick) begin
      bit_timer_q <= '0;
    end else begin
      bit_timer_q <= bit_timer_q + 16'h0001;
    end
  end

  // Transmit sequencer: SOP bits in frame mode, then body; clear stops it at once
  always_ff @(posedge sys_clk_i) begin
    if (reset_i || tx_clear || !tx_mode) begin
      tx_state_q   <= selftest_pkg::TX_IDLE;
      sop_index_q  <= '0;
      body_count_q <= '0;
      tx_bit_q     <= 1'b0;
      alt_q        <= 1'b0;
    end else begin
      case (tx_state_q)
        selftest_pkg::TX_IDLE: begin
          if (tx_go && !tx_go_q) begin
            tx_state_q <= framed ? selftest_pkg::TX_SOP : selftest_pkg::TX_BODY;
            tx_bit_q   <= framed ? sop_vec[0] : next_bit;
            sop_index_q  <= '0; // Counts left over from an ended frame
            body_count_q <= '0;
            alt_q      <= ~alt_q;
          end
        end
        selftest_pkg::TX_SOP: begin
          if (bit_tick) begin
            if (sop_last) begin
              tx_state_q <= selftest_pkg::TX_BODY;
              tx_bit_q   <= next_bit;
            end else begin
              sop_index_q <= sop_index_q + 5'd1;
              tx_bit_q    <= sop_vec[sop_index_q + 5'd1];
            end
          end
        end
        selftest_pkg::TX_BODY: begin
          if (bit_tick) begin
            if (body_end) begin
              tx_state_q <= selftest_pkg::TX_IDLE;
              tx_bit_q   <= 1'b0;
            end else begin
              body_count_q <= body_count_q + 11'd1;
              tx_bit_q     <= next_bit;
              alt_q        <= ~alt_q;
            end
          end
        end
        default: tx_state_q <= selftest_pkg::TX_IDLE;
      endcase
    end
  end

  assign tx_bit_o    = tx_bit_q;
  assign tx_active_o = tx_run;

  // Receive input synchronisers
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      rx_sync_q   <= '0;
    end else begin
      rx_sync_q   <= {rx_sync_q[1:0], rx_strobe_i};
    end
  end
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      rx_bit_d1_q <= 1'b0;
    end else begin
      rx_bit_d1_q <= rx_bit_i;
    end
  end
  logic rx_bit_d2_q;
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      rx_bit_d2_q <= 1'b0;
    end else begin
      rx_bit_d2_q <= rx_bit_d1_q;
    end
  end
  assign rx_bit_s    = rx_bit_d2_q;
  assign rx_strobe_s = rx_sync_q[1] && !rx_sync_q[2];

  // Receive checker: load generator with incoming bits, then compare
  logic rx_ref_bit;
  wire  rx_step = rx_mode && rx_strobe_s;
  wire  rx_mism = rx_step && rx_locked_q && (rx_ref_bit != rx_bit_s);
  selftest_prbs #(.SEED(selftest_pkg::PRBS_SEED)) u_rx_prbs (
    .sys_clk_i  (sys_clk_i),
    .reset_i    (reset_i),
    .restart_i  (!rx_mode),
    .step_i     (rx_step),
    .load_i     (!rx_locked_q),
    .load_bit_i (rx_bit_s),
    .bit_o      (rx_ref_bit)
  );

  // Lock after the generator has been filled with received bits
  always_ff @(posedge sys_clk_i) begin
    if (reset_i || !rx_mode) begin
      lock_count_q <= '0;
      rx_locked_q  <= 1'b0;
    end else if (rx_step && !rx_locked_q) begin
      lock_count_q <= lock_count_q + 5'd1;
      rx_locked_q  <= lock_count_q == 5'(selftest_pkg::LOCK_BITS - 1);
    end
  end

  // Error counter saturates; clear wins only when no error arrives
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      err_count_q <= '0;
      rx_error_q  <= 1'b0;
    end else if (rx_mism) begin
      err_count_q <= err_clr ? 16'h0001 : err_count_q + {15'h0000, ~&err_count_q};
      rx_error_q  <= 1'b1;
    end else if (err_clr) begin
      err_count_q <= '0;
      rx_error_q  <= 1'b0;
    end
  end

  // Sticky interrupt events; a new event beats a write-one clear
  logic [7:0] irq_events;
  logic       tx_run_d_q;
  always_comb begin
    irq_events = 8'h00;
    irq_events[selftest_pkg::IRQ_TX_DONE]  = tx_run_d_q && !tx_run;
    irq_events[selftest_pkg::IRQ_RX_LOCK]  = rx_step && !rx_locked_q &&
                                             lock_count_q == 5'(selftest_pkg::LOCK_BITS - 1);
    irq_events[selftest_pkg::IRQ_RX_ERROR] = rx_mism;
  end
  wire [7:0] irq_clear = (req.write && hit_ists) ? req.wdata : 8'h00;
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      irq_status_q <= selftest_pkg::RESET_BYTE;
      tx_run_d_q   <= 1'b0;
    end else begin
      irq_status_q <= (irq_status_q & ~irq_clear) | irq_events;
      tx_run_d_q   <= tx_run;
    end
  end
  assign irq_o = |(irq_status_q & irq_mask_q);

  // Read mux; unmapped addresses read zero
  wire [7:0] ctl_b_read = {6'h00, tx_go_q, 1'b0};
  wire [7:0] rx_stat    = {5'h00, rx_error_q, rx_mode, rx_locked_q};
  wire [7:0] read_mux   = hit_a    ? control_a_q :
                          hit_b    ? ctl_b_read :
                          hit_hi   ? err_count_q[15:8] :
                          hit_lo   ? err_count_q[7:0] :
                          hit_ists ? irq_status_q :
                          hit_imsk ? irq_mask_q :
                          hit_rxs  ? rx_stat : 8'h00;
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= req.read ? read_mux : 8'h00;
    end
  end
  assign rdata_o = rdata_q;

  // Checks
  sequence s_clear_write;
    tx_clear;
  endsequence
  chk_clear_stops_tx: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    s_clear_write |=> !tx_active_o) else $error("transmitter kept running after clear");
  chk_tx_mode_gate: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    tx_active_o |-> $past(tx_mode)) else $error("transmit ran outside transmit mode");
  chk_rx_mode_gate: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    rx_locked_q |-> rx_mode) else $error("receiver locked outside receive mode");
  chk_err_clear: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    err_clr && !rx_mism |=> err_count_q == 16'h0000) else $error("error count not cleared");
  chk_err_count_up: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    rx_mism && !err_clr && err_count_q != 16'hFFFF |=>
    err_count_q == $past(err_count_q) + 16'h0001) else $error("error not counted");
  chk_no_count_unlocked: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    !rx_locked_q && !err_clr |=> err_count_q == $past(err_count_q))
    else $error("counted before lock");
  chk_go_reads_run: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    tx_go && !tx_go_q && tx_mode && !tx_clear |=> tx_go_q ##0 tx_active_o)
    else $error("go did not start transmit");
  chk_sop_bit: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    tx_state_q == selftest_pkg::TX_SOP |-> tx_bit_q == sop_vec[sop_index_q])
    else $error("sop bit mismatch");
  chk_bit_period: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    tx_active_o && tx_mode && !tx_clear && !bit_tick |=> $stable(tx_bit_o))
    else $error("bit changed inside a bit time");
  chk_done_event: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    $fell(tx_active_o) |=> irq_status_q[selftest_pkg::IRQ_TX_DONE])
    else $error("transmit done event lost");
endmodule : selftest_engine
`default_nettype wire

/* File: bench/link_partner.sv */
// Link partner model driving the receive self-test stream
`timescale 1ns/1ps
`default_nettype none
module link_partner (
  input  wire logic sys_clk_i,
  input  wire logic reset_i,
  input  wire logic run_i,
  input  wire logic flip_i,
  output logic      rx_bit_o,
  output logic      rx_strobe_o
);
  logic [15:0] lfsr_q;
  logic [2:0]  phase_q;
  logic        flip_q;
  // Eight cycles a bit: data stable seven cycles, strobe high three
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      lfsr_q      <= selftest_pkg::PRBS_SEED;
      phase_q     <= 3'h0;
      rx_strobe_o <= 1'b0;
      rx_bit_o    <= 1'b0;
      flip_q      <= 1'b0;
    end else if (!run_i) begin
      lfsr_q      <= selftest_pkg::PRBS_SEED;
      phase_q     <= 3'h0;
      rx_strobe_o <= 1'b0;
      rx_bit_o    <= ~rx_bit_o; // Idle line shows no stale value
    end else begin
      phase_q     <= phase_q + 3'h1;
      rx_strobe_o <= (phase_q >= 3'h1) && (phase_q <= 3'h3);
      flip_q      <= (phase_q == 3'h0) ? flip_i : (flip_q | flip_i);
      if (phase_q == 3'h0) begin
        rx_bit_o <= lfsr_q[0] ^ flip_q;
        lfsr_q   <= {lfsr_q[0] ^ lfsr_q[2] ^ lfsr_q[3] ^ lfsr_q[5], lfsr_q[15:1]};
      end else if (phase_q == 3'h7) begin
        rx_bit_o <= ~rx_bit_o; // Hold time over
      end
    end
  end
endmodule : link_partner
`default_nettype wire

/* File: bench/tb_top.sv */
// Self-checking bench of the link self-test engine
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int BITC = 6;
  localparam int FRMB = 8;
  localparam logic [15:0] A_CA = selftest_pkg::ADDR_CONTROL_A;
  localparam logic [15:0] A_CB = selftest_pkg::ADDR_CONTROL_B;
  localparam logic [15:0] A_HI = selftest_pkg::ADDR_ERR_HIGH;
  localparam logic [15:0] A_LO = selftest_pkg::ADDR_ERR_LOW;
  localparam logic [15:0] A_IS = selftest_pkg::ADDR_IRQ_STATUS;
  localparam logic [15:0] A_IM = selftest_pkg::ADDR_IRQ_MASK;
  localparam logic [15:0] A_RS = selftest_pkg::ADDR_RX_STATUS;
  logic        sys_clk_i = 1'b0;
  logic        reset_i   = 1'b1;
  logic [15:0] addr_i    = 16'h0000;
  logic [7:0]  wdata_i   = 8'h00;
  logic        write_i   = 1'b0;
  logic        read_i    = 1'b0;
  logic        run_q     = 1'b0;
  logic        flip_q    = 1'b0;
  logic [7:0]  rdata_o;
  logic        irq_o;
  logic        tx_bit_o;
  logic        tx_active_o;
  logic        rx_bit;
  logic        rx_strobe;
  logic [7:0]  v;
  logic        bits [0:31];
  logic        alt_first;
  int          mismatches = 0;
  int          compares   = 0;
  // Clock
  always #5 sys_clk_i = ~sys_clk_i;
  selftest_engine #(.BIT_CYCLES(BITC), .FRAME_BITS(FRMB)) i_dut (
    .sys_clk_i(sys_clk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .write_i(write_i), .read_i(read_i), .rdata_o(rdata_o), .irq_o(irq_o),
    .tx_bit_o(tx_bit_o), .tx_active_o(tx_active_o), .rx_bit_i(rx_bit),
    .rx_strobe_i(rx_strobe));
  link_partner i_partner (
    .sys_clk_i(sys_clk_i), .reset_i(reset_i), .run_i(run_q), .flip_i(flip_q),
    .rx_bit_o(rx_bit), .rx_strobe_o(rx_strobe));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : tally_and_finish
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask : cyc
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    addr_i  <= a;
    wdata_i <= d;
    write_i <= 1'b1;
    @(posedge sys_clk_i);
    write_i <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    addr_i <= a;
    read_i <= 1'b1;
    @(posedge sys_clk_i);
    read_i <= 1'b0;
    #1;
    d = rdata_o;
  endtask : rd
  // Bounded wait for the transmit activity level
  task automatic wait_tx(input logic lvl, input int lim);
    int n;
    n = 0;
    while (tx_active_o !== lvl && n < lim) begin
      cyc(1);
      n++;
    end
    check(tx_active_o, lvl, "transmit active level");
    if (tx_active_o !== lvl) tally_and_finish();
  endtask : wait_tx
  task automatic start_tx(input logic [7:0] ctl);
    wr(A_CA, ctl);
    wr(A_CB, 8'h01);
    wr(A_CB, 8'h02);
    wait_tx(1'b1, 4);
    cyc(BITC / 2);
  endtask : start_tx
  // Sample each bit in its middle
  task automatic grab(input int n);
    for (int i = 0; i < n; i++) begin
      bits[i] = tx_bit_o;
      check(tx_active_o, 1'b1, "active in frame");
      cyc(BITC);
    end
  endtask : grab
  task automatic stop_tx();
    wr(A_CB, 8'h01);
    wait_tx(1'b0, BITC);
    cyc(BITC);
    wr(A_CA, 8'h00);
  endtask : stop_tx
  task automatic t_registers();
    for (int a = 0; a < 8; a++) begin
      rd(A_CA + 16'(a), v);
      check(v, 8'h00, "reset value");
    end
    wr(16'h1AC6, 8'hFF);
    rd(16'h1AC6, v);
    check(v, 8'h00, "unmapped read");
    wr(A_LO, 8'hFF);
    rd(A_LO, v);
    check(v, 8'h00, "count is read only");
    wr(A_CA, 8'hFC);
    rd(A_CA, v);
    check(v, 8'hFC, "control readback");
    wr(A_CA, 8'h00);
  endtask : t_registers
  task automatic t_continuous();
    logic [2:0]  modes [5] = '{3'h1, 3'h2, 3'h3, 3'h5, 3'h0};
    logic        ok;
    logic [15:0] lf;
    for (int m = 0; m < 5; m++) begin
      start_tx(8'h01 | {3'h0, modes[m], 2'b00});
      grab(32);
      rd(A_CB, v);
      check(v[1], 1'b1, "running flag");
      lf = selftest_pkg::PRBS_SEED;
      for (int i = 0; i < 32; i++) begin
        case (modes[m])
          3'h1: ok = bits[i];
          3'h2: ok = !bits[i];
          3'h3, 3'h5: ok = (i == 0) || (bits[i] != bits[i-1]);
          default: ok = bits[i] == (lf[15] ^ lf[13] ^ lf[12] ^ lf[10]);
        endcase
        lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
        check(ok, 1'b1, "pattern bit");
      end
      if (modes[m] == 3'h3) alt_first = bits[0];
      if (modes[m] == 3'h5) check(bits[0], !alt_first, "inverted start");
      stop_tx();
    end
  endtask : t_continuous
  task automatic t_framed();
    logic [19:0] sops [5] = '{selftest_pkg::SOP_SET0, selftest_pkg::SOP_SET1,
      selftest_pkg::SOP_SET2, selftest_pkg::SOP_SET3, selftest_pkg::SOP_SET4};
    logic [2:0]  sels [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
    logic [15:0] lf;
    for (int k = 0; k < 6; k++) begin
      start_tx({sels[k], 5'h11});
      grab(20 + FRMB);
      for (int i = 0; i < 20; i++) begin
        check(bits[i], sops[(sels[k] > 3'h4) ? 3'h4 : sels[k]][i], "start vector bit");
      end
      lf = selftest_pkg::PRBS_SEED;
      for (int i = 0; i < FRMB; i++) begin
        check(bits[20 + i], lf[15] ^ lf[13] ^ lf[12] ^ lf[10], "frame body bit");
        lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
      end
      wait_tx(1'b0, BITC);
      wr(A_CA, 8'h00);
    end
    rd(A_IS, v);
    check(v, 8'h01, "done event");
    check(irq_o, 1'b0, "masked irq");
    wr(A_IM, 8'h01);
    check(irq_o, 1'b1, "unmasked irq");
    wr(A_IS, 8'h01);
    check(irq_o, 1'b0, "cleared irq");
  endtask : t_framed
  task automatic t_rx();
    wr(A_CA, 8'h03);
    wr(A_CB, 8'h01);
    wr(A_CB, 8'h02);
    cyc(4);
    check(tx_active_o, 1'b0, "no send in receive mode");
    rd(A_CB, v);
    check(v[1], 1'b0, "go refused");
    run_q <= 1'b1;
    cyc(8 * 24);
    rd(A_RS, v);
    check(v, 8'h03, "locked receive");
    rd(A_LO, v);
    check(v, 8'h00, "clean stream");
    repeat (3) begin
      flip_q <= 1'b1;
      cyc(1);
      flip_q <= 1'b0;
      cyc(15);
    end
    cyc(8 * 8);
    run_q <= 1'b0;
    cyc(16);
    rd(A_HI, v);
    check(v, 8'h00, "count high");
    rd(A_LO, v);
    check(v, 8'h03, "count low");
    rd(A_RS, v);
    check(v, 8'h07, "error seen");
    rd(A_IS, v);
    check(v, 8'h06, "receive events");
    wr(A_IM, 8'h04);
    check(irq_o, 1'b1, "error irq");
    wr(A_IS, 8'h06);
    check(irq_o, 1'b0, "error irq cleared");
    wr(A_CB, 8'h04);
    rd(A_LO, v);
    check(v, 8'h00, "count cleared");
    wr(A_CA, 8'h00);
  endtask : t_rx
  initial begin
    repeat (20) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    cyc(1);
    t_registers();
    t_continuous();
    t_framed();
    t_rx();
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
